// [ocg_pkg.sv]
package ocg_pkg;

	// Register byte addresses on the AHB-Lite slave.
	localparam logic [13:0] ADDR_CTRL = 14'h0000;
	localparam logic [13:0] ADDR_VSTART = 14'h0004;
	localparam logic [13:0] ADDR_HSTART = 14'h0008;
	localparam logic [13:0] ADDR_VSPACE = 14'h000C;
	localparam logic [13:0] ADDR_HSPACE = 14'h0010;
	localparam logic [13:0] ADDR_BGCTRL = 14'h0014;
	localparam logic [13:0] ADDR_BANK = 14'h0018;
	localparam logic [13:0] ADDR_STATUS = 14'h001C;
	// Display memory window: 80 words from this base, one byte each.
	localparam logic [3:0] DRAM_PAGE = 4'h1;
	localparam logic [6:0] DRAM_WORDS = 7'h50;
	// Glyph memory window: selected by this bit, {bank, glyph, row} word index below it.
	localparam int GRAM_SEL_BIT = 13;
	localparam int GRAM_WORDS = 2048;

	// Reset values; zero vertical start and spacing codes are illegal.
	localparam logic [7:0] RST_VSTART = 8'h01;
	localparam logic [7:0] RST_VSPACE = 8'h01;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Register field positions.
	localparam int FIELD6_MSB = 5;
	localparam int FRINGE_BIT = 6;
	localparam int SPACE_BLANK_DIS_BIT = 6;
	localparam int SCREEN_BLANK_BIT = 6;
	localparam int GS_LO_BIT = 6;
	localparam int GS_HI_BIT = 7;
	localparam int BG0_EN_BIT = 3;
	localparam int BG1_EN_BIT = 7;
	localparam int BG1_COL_LSB = 4;
	localparam int ST_ROW_BIT = 3;
	localparam int ST_CELL_BIT = 4;

	// Display memory code fields.
	localparam int CODE_SPACE_BIT = 6;
	localparam int SPC_WORDGAP_BIT = 5;
	localparam int FMT_SIZE_BIT = 5;
	localparam int FMT_LINEGAP_BIT = 6;
	localparam int ATTR_MSB = 4;
	localparam int GLYPH_MSB = 5;

	// Screen geometry and timing in scan lines and oscillator periods.
	localparam logic [2:0] LAST_LINE = 3'h4;
	localparam logic [3:0] FIRST_COL = 4'h1;
	localparam logic [3:0] LAST_COL = 4'hF;
	localparam logic [3:0] LAST_ROW = 4'h8;
	localparam logic [2:0] LAST_DOT = 3'h5;
	localparam logic [6:0] HSTART_BASE = 7'h0A;
	localparam int OSC_PER_DOT = 2;
	localparam int VSTEP_SHIFT = 2;

	typedef struct packed {
		logic we;
		logic backdrop_select;
		logic [2:0] colour;
	} ocg_attr_t;

	typedef struct packed {
		logic blank;
		logic [2:0] rgb;
	} ocg_video_t;

	typedef enum logic [1:0] {V_IDLE, V_WAIT, V_ROW, V_GAP} ocg_vstate_t;
	typedef enum logic [1:0] {H_IDLE, H_WAIT, H_CELL} ocg_hstate_t;

endpackage

// [ocg_overlay.sv]
// Operation
// - Timing follows hsync and vsync inputs; output is RGB plus blanking.
// - Screen holds five text lines of fifteen character columns.
// - 128 glyphs in two banks of 64; one bank per screen.
// - Master enable low shows no words but still obeys screen blank; high defers to each word flag.
// - First entry of each line is a format code, never drawn.
// - Bit 6 set means space code; clear selects one of 64 glyphs.
// - Glyphs are 6x9 dots; smallest dot is 2 lines by 2 clocks.
// - With both gap enables clear, characters and lines abut.
// - Size bits hi, lo, s pick scale one to four per line.
// - At most two heights per screen, chosen per line.
// - Line gap enable adds programmed vertical spacing, else none.
// - Word gap is the space glyph, plus programmed spacing if enabled.
// - Three colour bits, red on top, set the following word colour.
// - Backdrop select picks set zero or one, each with enable, colour.
// - Hidden word never drawn; shown word needs master enable too.
// - Five attribute bits hold colour, backdrop choice and visibility.
// - Space codes have bit 6 set; their top bit is ignored.
// - Origin has 64 horizontal steps of 2 clocks, 63 of 4 lines.
// - Extra word gap spans 64 steps of 2 clocks times the line scale.
// - Line gap spans 4 to 252 scan lines in 63 steps.
// - Per word: backdrop or none; box or outline fringe is chosen per screen.
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
module ocg_overlay (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Sync inputs, active high
	input wire logic hsyncIn,
	input wire logic vsyncIn,
	// Video output
	output ocg_pkg::ocg_video_t videoOut,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);

	logic [7:0] dram [0:79];
	logic [5:0] gram [0:ocg_pkg::GRAM_WORDS-1];

	logic ctrlEn_q, bank_q;
	logic [7:0] vstart_q, hstart_q, vspace_q, hspace_q, bgctrl_q;
	logic wrPend_q, rdPend_q;
	logic [13:0] addr_q;
	logic [31:0] hrdata_q;
	logic [1:0] syncA_q, syncB_q, syncC_q, syncLvl_q;
	logic [1:0] syncAgree, syncRise;
	logic hsRise, vsRise;
	ocg_pkg::ocg_vstate_t vState_q;
	ocg_pkg::ocg_hstate_t hState_q;
	logic [2:0] textLine_q, vSub_q, hSub_q, dot_q;
	logic [3:0] row_q, col_q;
	logic [7:0] vCnt_q, hCnt_q;
	logic [9:0] xCnt_q;
	logic inExtra_q;
	ocg_pkg::ocg_attr_t attr_q;
	ocg_pkg::ocg_video_t video_q;

	function automatic logic [2:0] sizeScale(input logic hi, input logic lo,
		input logic s);
		case ({hi, lo, s})
			3'h0, 3'h2: sizeScale = 3'h1;
			3'h1, 3'h4, 3'h6: sizeScale = 3'h2;
			3'h3, 3'h5: sizeScale = 3'h3;
			default: sizeScale = 3'h4;
		endcase
	endfunction

	function automatic logic fringeHit(input logic [5:0] a, input logic [5:0] b,
		input logic [5:0] c, input logic [2:0] d);
		logic [7:0] pa, pb, pc;
		int p;
		pa = {1'b0, a, 1'b0};
		pb = {1'b0, b, 1'b0};
		pc = {1'b0, c, 1'b0};
		p = 6 - int'(d);
		fringeHit = pa[p-1] | pa[p] | pa[p+1] | pb[p-1] | pb[p+1] |
			pc[p-1] | pc[p] | pc[p+1];
	endfunction

	function automatic logic isDram(input logic [13:0] a);
		isDram = (a[13:10] == ocg_pkg::DRAM_PAGE) && (a[8:2] < ocg_pkg::DRAM_WORDS);
	endfunction

	// Sync inputs: three stages, a level counts once stages two and three agree.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			syncA_q <= 2'h0;
			syncB_q <= 2'h0;
			syncC_q <= 2'h0;
			syncLvl_q <= 2'h0;
		end else begin
			syncA_q <= {vsyncIn, hsyncIn};
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
			syncLvl_q <= (syncLvl_q & ~syncAgree) | (syncC_q & syncAgree);
		end
	end
	assign syncAgree = ~(syncB_q ^ syncC_q);
	assign syncRise = syncAgree & syncC_q & ~syncLvl_q;
	assign hsRise = syncRise[0];
	assign vsRise = syncRise[1];

	// Current line format and scale.
	logic [7:0] fmtCode, curEntry, nextEntry;
	logic [2:0] lineScale, subLim;
	logic [7:0] vStartLines, vGapLines, hStartLim;
	logic [9:0] xLim;
	assign fmtCode = dram[{textLine_q, 4'h0}];
	assign curEntry = dram[{textLine_q, col_q}];
	assign nextEntry = dram[{textLine_q, col_q + 4'h1}];
	assign lineScale = sizeScale(hspace_q[ocg_pkg::GS_HI_BIT],
		hspace_q[ocg_pkg::GS_LO_BIT], fmtCode[ocg_pkg::FMT_SIZE_BIT]);
	assign subLim = 3'(({1'b0, lineScale} * 4'(ocg_pkg::OSC_PER_DOT)) - 4'h1);
	assign vStartLines = {vstart_q[ocg_pkg::FIELD6_MSB:0], 2'b00};
	assign vGapLines = {vspace_q[ocg_pkg::FIELD6_MSB:0], 2'b00};
	assign hStartLim = 8'({1'b0, 7'(hstart_q[ocg_pkg::FIELD6_MSB:0]) +
		ocg_pkg::HSTART_BASE} * 8'(ocg_pkg::OSC_PER_DOT) - 8'h01);
	assign xLim = 10'(({4'h0, hspace_q[ocg_pkg::FIELD6_MSB:0]} + 10'h001) *
		10'(ocg_pkg::OSC_PER_DOT) * {7'h00, lineScale} - 10'h001);

	// Vertical walk: wait for origin, rows of dots, optional line gap.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vState_q <= ocg_pkg::V_IDLE;
			vCnt_q <= 8'h00;
			textLine_q <= 3'h0;
			row_q <= 4'h0;
			vSub_q <= 3'h0;
		end else if (vsRise) begin
			vState_q <= ocg_pkg::V_WAIT;
			vCnt_q <= 8'h00;
			textLine_q <= 3'h0;
			row_q <= 4'h0;
			vSub_q <= 3'h0;
		end else if (hsRise) begin
			case (vState_q)
				ocg_pkg::V_WAIT: begin
					if (vCnt_q + 8'h01 >= vStartLines) begin
						vState_q <= ocg_pkg::V_ROW;
					end else begin
						vCnt_q <= vCnt_q + 8'h01;
					end
				end
				ocg_pkg::V_ROW: begin
					if (vSub_q != subLim) begin
						vSub_q <= vSub_q + 3'h1;
					end else if (row_q != ocg_pkg::LAST_ROW) begin
						vSub_q <= 3'h0;
						row_q <= row_q + 4'h1;
					end else begin
						vSub_q <= 3'h0;
						row_q <= 4'h0;
						vCnt_q <= 8'h00;
						if (fmtCode[ocg_pkg::FMT_LINEGAP_BIT]) begin
							vState_q <= ocg_pkg::V_GAP;
						end else if (textLine_q == ocg_pkg::LAST_LINE) begin
							vState_q <= ocg_pkg::V_IDLE;
						end else begin
							textLine_q <= textLine_q + 3'h1;
						end
					end
				end
				ocg_pkg::V_GAP: begin
					if (vCnt_q + 8'h01 < vGapLines) begin
						vCnt_q <= vCnt_q + 8'h01;
					end else if (textLine_q == ocg_pkg::LAST_LINE) begin
						vState_q <= ocg_pkg::V_IDLE;
					end else begin
						vState_q <= ocg_pkg::V_ROW;
						textLine_q <= textLine_q + 3'h1;
					end
				end
				default: vState_q <= vState_q;
			endcase
		end
	end

	// Horizontal walk along one scan line.
	logic curSpace, dotEnd, goExtra, xEnd, advance, cellStart;
	assign curSpace = curEntry[ocg_pkg::CODE_SPACE_BIT];
	assign dotEnd = (hState_q == ocg_pkg::H_CELL) && !inExtra_q &&
		(hSub_q == subLim) && (dot_q == ocg_pkg::LAST_DOT);
	assign goExtra = dotEnd && curSpace && curEntry[ocg_pkg::SPC_WORDGAP_BIT];
	assign xEnd = (hState_q == ocg_pkg::H_CELL) && inExtra_q && (xCnt_q == xLim);
	assign advance = !hsRise && ((dotEnd && !goExtra) || xEnd);
	assign cellStart = !hsRise && (hState_q == ocg_pkg::H_WAIT) &&
		(hCnt_q == hStartLim) && (vState_q == ocg_pkg::V_ROW);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hState_q <= ocg_pkg::H_IDLE;
			hCnt_q <= 8'h00;
			col_q <= 4'h0;
			hSub_q <= 3'h0;
			dot_q <= 3'h0;
			xCnt_q <= 10'h000;
			inExtra_q <= 1'b0;
		end else if (hsRise) begin
			hState_q <= ocg_pkg::H_WAIT;
			hCnt_q <= 8'h00;
			col_q <= 4'h0;
			inExtra_q <= 1'b0;
		end else begin
			case (hState_q)
				ocg_pkg::H_WAIT: begin
					if (cellStart) begin
						hState_q <= ocg_pkg::H_CELL;
						col_q <= ocg_pkg::FIRST_COL;
						hSub_q <= 3'h0;
						dot_q <= 3'h0;
					end else if (hCnt_q == hStartLim) begin
						hState_q <= ocg_pkg::H_IDLE;
					end else begin
						hCnt_q <= hCnt_q + 8'h01;
					end
				end
				ocg_pkg::H_CELL: begin
					if (goExtra) begin
						inExtra_q <= 1'b1;
						xCnt_q <= 10'h000;
					end else if (inExtra_q && !xEnd) begin
						xCnt_q <= xCnt_q + 10'h001;
					end else if (!inExtra_q && hSub_q != subLim) begin
						hSub_q <= hSub_q + 3'h1;
					end else if (!inExtra_q && !dotEnd) begin
						hSub_q <= 3'h0;
						dot_q <= dot_q + 3'h1;
					end
					if (advance) begin
						inExtra_q <= 1'b0;
						hSub_q <= 3'h0;
						dot_q <= 3'h0;
						if (col_q == ocg_pkg::LAST_COL) begin
							hState_q <= ocg_pkg::H_IDLE;
						end else begin
							col_q <= col_q + 4'h1;
						end
					end
				end
				default: hState_q <= hState_q;
			endcase
		end
	end

	// Word attributes: format code opens a line, each space code past column one replaces them.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			attr_q <= '0;
		end else if (cellStart) begin
			attr_q <= ocg_pkg::ocg_attr_t'(fmtCode[ocg_pkg::ATTR_MSB:0]);
		end else if (advance && col_q != ocg_pkg::LAST_COL &&
			nextEntry[ocg_pkg::CODE_SPACE_BIT]) begin
			attr_q <= ocg_pkg::ocg_attr_t'(nextEntry[ocg_pkg::ATTR_MSB:0]);
		end
	end

	// Pixel generation. Fringe only looks inside the current cell, trading a
	// slightly clipped outline at cell edges for three glyph reads, not nine.
	logic [10:0] gBase;
	logic [5:0] rowMid, rowUp, rowDn;
	logic pixOn, bgEn, bgOn, visible, inSpace;
	logic [2:0] bgCol;
	assign gBase = {bank_q, curEntry[ocg_pkg::GLYPH_MSB:0], 4'h0};
	assign rowMid = gram[gBase + {7'h00, row_q}];
	assign rowUp = (row_q == 4'h0) ? 6'h00 : gram[gBase + {7'h00, row_q - 4'h1}];
	assign rowDn = (row_q == ocg_pkg::LAST_ROW) ? 6'h00 :
		gram[gBase + {7'h00, row_q + 4'h1}];
	assign inSpace = curSpace || inExtra_q;
	assign pixOn = !inSpace && rowMid[3'(ocg_pkg::LAST_DOT - dot_q)];
	assign bgEn = attr_q.backdrop_select ? bgctrl_q[ocg_pkg::BG1_EN_BIT] :
		bgctrl_q[ocg_pkg::BG0_EN_BIT];
	assign bgCol = attr_q.backdrop_select ? bgctrl_q[ocg_pkg::BG1_COL_LSB +: 3] :
		bgctrl_q[2:0];
	always_comb begin
		if (vstart_q[ocg_pkg::FRINGE_BIT]) begin
			bgOn = bgEn && !inSpace && !pixOn &&
				fringeHit(rowUp, rowMid, rowDn, dot_q);
		end else begin
			bgOn = bgEn && !(inSpace && hstart_q[ocg_pkg::SPACE_BLANK_DIS_BIT]);
		end
	end
	assign visible = ctrlEn_q && attr_q.we && (hState_q == ocg_pkg::H_CELL) &&
		(vState_q == ocg_pkg::V_ROW);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			video_q <= '0;
		end else begin
			video_q.blank <= vspace_q[ocg_pkg::SCREEN_BLANK_BIT] ||
				(visible && (pixOn || bgOn));
			if (visible && pixOn) begin
				video_q.rgb <= attr_q.colour;
			end else if (visible && bgOn) begin
				video_q.rgb <= bgCol;
			end else begin
				video_q.rgb <= 3'h0;
			end
		end
	end
	assign videoOut = video_q;

	// AHB-Lite: writes have no wait state, reads one, so a read that follows
	// a write always sees the committed value.
	logic addrOk;
	assign addrOk = hsel && htrans[1] && hready;
	assign hreadyout = !rdPend_q;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
			addr_q <= 14'h0000;
		end else begin
			wrPend_q <= addrOk && hwrite;
			rdPend_q <= addrOk && !hwrite;
			if (addrOk) begin
				addr_q <= haddr[13:0];
			end
		end
	end

	// Everything but the enable is locked while the overlay is showing.
	logic wrOpen;
	assign wrOpen = wrPend_q && !ctrlEn_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrlEn_q <= 1'b0;
			vstart_q <= ocg_pkg::RST_VSTART;
			hstart_q <= ocg_pkg::RST_ZERO;
			vspace_q <= ocg_pkg::RST_VSPACE;
			hspace_q <= ocg_pkg::RST_ZERO;
			bgctrl_q <= ocg_pkg::RST_ZERO;
			bank_q <= 1'b0;
		end else begin
			if (wrPend_q && addr_q == ocg_pkg::ADDR_CTRL) begin
				ctrlEn_q <= hwdata[0];
			end
			if (wrOpen) begin
				case (addr_q)
					ocg_pkg::ADDR_VSTART: vstart_q <= {1'b0, hwdata[6:0]};
					ocg_pkg::ADDR_HSTART: hstart_q <= {1'b0, hwdata[6:0]};
					ocg_pkg::ADDR_VSPACE: vspace_q <= {1'b0, hwdata[6:0]};
					ocg_pkg::ADDR_HSPACE: hspace_q <= hwdata[7:0];
					ocg_pkg::ADDR_BGCTRL: bgctrl_q <= hwdata[7:0];
					ocg_pkg::ADDR_BANK: bank_q <= hwdata[0];
					default: bank_q <= bank_q;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (wrOpen && isDram(addr_q)) begin
			dram[addr_q[8:2]] <= hwdata[7:0];
		end
		if (wrOpen && addr_q[ocg_pkg::GRAM_SEL_BIT]) begin
			gram[addr_q[12:2]] <= hwdata[5:0];
		end
	end

	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		if (addr_q[ocg_pkg::GRAM_SEL_BIT]) begin
			rdMux = {26'h000_0000, gram[addr_q[12:2]]};
		end else if (isDram(addr_q)) begin
			rdMux = {24'h00_0000, dram[addr_q[8:2]]};
		end else begin
			case (addr_q)
				ocg_pkg::ADDR_CTRL: rdMux = {31'h0000_0000, ctrlEn_q};
				ocg_pkg::ADDR_VSTART: rdMux = {24'h00_0000, vstart_q};
				ocg_pkg::ADDR_HSTART: rdMux = {24'h00_0000, hstart_q};
				ocg_pkg::ADDR_VSPACE: rdMux = {24'h00_0000, vspace_q};
				ocg_pkg::ADDR_HSPACE: rdMux = {24'h00_0000, hspace_q};
				ocg_pkg::ADDR_BGCTRL: rdMux = {24'h00_0000, bgctrl_q};
				ocg_pkg::ADDR_BANK: rdMux = {31'h0000_0000, bank_q};
				ocg_pkg::ADDR_STATUS: begin
					rdMux[2:0] = textLine_q;
					rdMux[ocg_pkg::ST_ROW_BIT] = (vState_q == ocg_pkg::V_ROW);
					rdMux[ocg_pkg::ST_CELL_BIT] = (hState_q == ocg_pkg::H_CELL);
				end
				default: rdMux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rdPend_q) begin
			hrdata_q <= rdMux;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_wordEnd;
		(hState_q == ocg_pkg::H_CELL) && dotEnd && curSpace &&
			!curEntry[ocg_pkg::SPC_WORDGAP_BIT];
	endsequence
	sequence s_spaceOpens;
		advance && col_q != ocg_pkg::LAST_COL && nextEntry[ocg_pkg::CODE_SPACE_BIT];
	endsequence

	a_master_off_dark: assert property (!ctrlEn_q |=> videoOut.rgb == 3'h0)
		else $error("colour shown while master enable is low");
	a_hidden_word: assert property (!attr_q.we |=> videoOut.rgb == 3'h0)
		else $error("hidden word produced colour");
	a_format_never_drawn: assert property (
		hState_q == ocg_pkg::H_CELL |-> col_q != 4'h0)
		else $error("format code column entered drawing");
	a_five_lines: assert property (vState_q == ocg_pkg::V_ROW |-> textLine_q <= 3'h4)
		else $error("text line beyond the fifth");
	a_two_heights: assert property (vState_q == ocg_pkg::V_ROW |->
		lineScale == sizeScale(hspace_q[7], hspace_q[6], 1'b0) ||
		lineScale == sizeScale(hspace_q[7], hspace_q[6], 1'b1))
		else $error("line height outside the screen pair");
	a_space_attr_load: assert property (s_spaceOpens |=>
		attr_q == ocg_pkg::ocg_attr_t'($past(nextEntry[4:0])))
		else $error("space code attributes not taken");
	a_no_word_gap: assert property (s_wordEnd and !hsRise |=> !inExtra_q)
		else $error("extra word gap without word gap enable");
	a_origin_start: assert property (cellStart |=>
		hState_q == ocg_pkg::H_CELL && col_q == 4'h1 ##1 hSub_q == 3'h1)
		else $error("line did not start at first glyph column");
	a_sync_filtered: assert property (hsRise |-> syncB_q[0] && syncC_q[0])
		else $error("sync edge taken before stages agreed");
	a_locked_regs: assert property (wrPend_q && ctrlEn_q |=> $stable(bgctrl_q))
		else $error("setting changed while overlay enabled");

endmodule // ocg_overlay

// [ocg_tv_model.sv]
module ocg_tv_model #(
	parameter int LINE_CLK = 160,
	parameter int FRAME_LINES = 12,
	parameter int PULSE = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Sync pulses and the current scan line
	output logic hsyncOut,
	output logic vsyncOut,
	output logic [7:0] lineNum
);
	timeunit 1ns;
	timeprecision 100ps;

	// Vertical sync sits mid-line so it never lands on a horizontal one.
	localparam int VPOS = 60;
	logic [7:0] pos_q;
	logic [7:0] line_q;
	logic hsync_q;
	logic vsync_q;
	logic lastLine;

	assign lastLine = int'(line_q) == FRAME_LINES - 1;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pos_q <= 8'h00;
			line_q <= 8'h00;
		end else if (int'(pos_q) == LINE_CLK - 1) begin
			pos_q <= 8'h00;
			line_q <= lastLine ? 8'h00 : line_q + 8'h01;
		end else begin
			pos_q <= pos_q + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hsync_q <= 1'b0;
			vsync_q <= 1'b0;
		end else begin
			hsync_q <= int'(pos_q) < PULSE;
			vsync_q <= line_q == 8'h00 && int'(pos_q) >= VPOS &&
				int'(pos_q) < VPOS + PULSE;
		end
	end

	assign hsyncOut = hsync_q;
	assign vsyncOut = vsync_q;
	assign lineNum = line_q;
endmodule // ocg_tv_model

// [tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		int line;
		logic [2:0] col;
		int cnt;
		int span;
		int first;
	} ocg_note_t;

	localparam int SCALE [8] = '{1, 2, 1, 3, 2, 3, 2, 4};
	localparam logic [13:0] RADDR [7] = '{ocg_pkg::ADDR_CTRL,
		ocg_pkg::ADDR_VSTART, ocg_pkg::ADDR_HSTART, ocg_pkg::ADDR_VSPACE,
		ocg_pkg::ADDR_HSPACE, ocg_pkg::ADDR_BGCTRL, ocg_pkg::ADDR_BANK};
	localparam logic [7:0] RST [7] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
		8'h00, 8'h00};
	localparam logic [7:0] MASK [7] = '{8'h01, 8'h7F, 8'h7F, 8'h7F, 8'hFF,
		8'hFF, 8'h01};

	logic clk, resetn, hsyncIn, vsyncIn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, seed, v;
	logic [7:0] lineNum;
	ocg_pkg::ocg_video_t videoOut;
	int nMismatch = 0;
	int numChecks = 0;
	logic [31:0] rdQ [$];
	ocg_note_t vidQ [$];
	logic rdPend = 1'b0;
	logic busy = 1'b0;
	logic vsPrev = 1'b0;
	int lastLine = 0;
	int pos, firstPos, lastPos, cnt, mCnt, mSpan, firstLine;

	ocg_overlay dut (.clk(clk), .resetn(resetn), .hsyncIn(hsyncIn),
		.vsyncIn(vsyncIn), .videoOut(videoOut), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp));
	ocg_tv_model tv (.clk(clk), .resetn(resetn), .hsyncOut(hsyncIn),
		.vsyncOut(vsyncIn), .lineNum(lineNum));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] ra(input int i);
		return {18'h0, RADDR[i]};
	endfunction

	function automatic logic [31:0] dm(input int i);
		return 32'h400 + 32'(i) * 32'h4;
	endfunction

	function automatic logic [31:0] gm(input int b, input int g, input int r);
		return 32'h2000 + 32'((b * 64 + g) * 16 + r) * 32'h4;
	endfunction

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input int got, input int exp, input string what);
		numChecks++;
		if (got != exp) begin
			$display("wrong value at %0t: %s got %0d expected %0d", $time,
				what, got, exp);
			nMismatch++;
		end
	endtask

	// The address phase is held until hready is seen high, then the data.
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(negedge clk);
		while (hreadyout !== 1'b1) @(negedge clk);
		@(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(negedge clk);
		while (hreadyout !== 1'b1) @(negedge clk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		rdQ.push_back(e);
		ahb(1'b0, a, 32'h0);
	endtask

	// Settings change only while the master enable is low.
	task automatic scene(input logic [7:0] c [4], input logic [7:0] hsp,
		input logic [7:0] bg, input logic [7:0] vst, input logic [1:0] ctl,
		input ocg_note_t n);
		wr(ra(0), 32'h0);
		for (int k = 0; k < 4; k++) wr(dm(k), {24'h0, c[k]});
		wr(ra(4), {24'h0, hsp});
		wr(ra(5), {24'h0, bg});
		wr(ra(1), {24'h0, vst});
		wr(ra(6), {31'h0, ctl[1]});
		wr(ra(0), {31'h0, ctl[0]});
		vidQ.push_back(n);
		wait (vidQ.size() == 0);
	endtask

	always @(negedge clk) begin
		if (hreadyout === 1'b1) begin
			if (rdPend) begin
				numChecks += 2;
				if (hrdata !== rdQ[0]) begin
					$display("wrong value at %0t: read data %h", $time, hrdata);
					nMismatch++;
				end
				if (hresp !== 1'b0) begin
					$display("wrong value at %0t: response not OKAY", $time);
					nMismatch++;
				end
				void'(rdQ.pop_front());
			end
			rdPend = hsel && htrans[1] && !hwrite;
		end
	end

	always @(negedge clk) begin
		if (int'(lineNum) != lastLine) begin
			if (busy && lastLine == vidQ[0].line) begin
				mCnt = cnt;
				mSpan = (firstPos < 0) ? 0 : lastPos - firstPos + 1;
			end
			lastLine = int'(lineNum);
			pos = 0;
			cnt = 0;
			firstPos = -1;
		end
		pos++;
		if (busy && lineNum != 8'h00 && videoOut.blank === 1'b1) begin
			if (firstPos < 0) firstPos = pos;
			lastPos = pos;
			if (videoOut.rgb === vidQ[0].col) cnt++;
			if (firstLine == 0) firstLine = int'(lineNum);
		end
		if (vsyncIn && !vsPrev) begin
			if (busy) begin
				check(mCnt, vidQ[0].cnt, "coloured dots");
				check(mSpan, vidQ[0].span, "lit span");
				check(firstLine, vidQ[0].first, "first lit line");
				void'(vidQ.pop_front());
				busy = 1'b0;
			end else if (vidQ.size() != 0) begin
				busy = 1'b1;
				firstLine = 0;
				mCnt = 0;
				mSpan = 0;
			end
		end
		vsPrev = vsyncIn;
	end

	initial begin
		// Fifteen scenes of at most two frames each, plus the register loads.
		repeat (90000) @(posedge clk);
		nMismatch++;
		printVerdict();
	end

	initial begin
		seed = 32'hC109;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		resetn = 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(ra(i), {24'h0, RST[i]});
		rd(32'h20, 32'h0);
		for (int i = 1; i < 7; i++) begin
			v = $random(seed);
			wr(ra(i), v);
			rd(ra(i), v & {24'h0, MASK[i]});
			wr(ra(i), {24'h0, RST[i]});
		end
		wr(ra(0), 32'h1);
		wr(ra(4), 32'h3F);
		rd(ra(4), 32'h0);
		rd(ra(0), 32'h1);
		wr(ra(0), 32'h0);
		for (int i = 0; i < 80; i++) wr(dm(i), 32'h48);
		for (int r = 0; r < 9; r++) begin
			wr(gm(0, 1, r), 32'h3F);
			wr(gm(1, 1, r), 32'h0);
			wr(gm(0, 2, r), 32'h0);
		end
		for (int i = 0; i < 8; i++) begin
			v = {26'h0, i[0], 2'h2, i[2:0]};
			scene('{v[7:0], 8'h01, 8'h01, 8'h48}, {i[2], i[1], 6'h0}, 8'h00,
				8'h01, 2'h1, '{6, i[2:0], 24 * SCALE[i], 24 * SCALE[i],
				4});
		end
		scene('{8'h14, 8'h01, 8'h01, 8'h48}, 8'h00, 8'h00, 8'h01, 2'h0,
			'{6, 3'h4, 0, 0, 0});
		scene('{8'h04, 8'h01, 8'h01, 8'h48}, 8'h00, 8'h00, 8'h01, 2'h1,
			'{6, 3'h4, 0, 0, 0});
		scene('{8'h14, 8'h01, 8'h01, 8'h48}, 8'h00, 8'h00, 8'h01, 2'h3,
			'{6, 3'h4, 0, 0, 0});
		v = $random(seed) & 32'h1F;
		scene('{8'h14, 8'h01, 8'hF2, 8'h01}, v[7:0], 8'h00, 8'h01, 2'h1,
			'{6, 3'h2, 12, 38 + 2 * int'(v), 4});
		scene('{8'h14, 8'h01, 8'hD2, 8'h01}, 8'h00, 8'h00, 8'h02, 2'h1,
			'{10, 3'h2, 12, 36, 8});
		scene('{8'h11, 8'h02, 8'h48, 8'h48}, 8'h00, 8'h0B, 8'h01, 2'h1,
			'{6, 3'h3, 12, 12, 4});
		scene('{8'h19, 8'h02, 8'h48, 8'h48}, 8'h00, 8'h0B, 8'h01, 2'h1,
			'{6, 3'h3, 0, 0, 0});
		printVerdict();
	end
endmodule // tb
